// *** logic/csf_pkg.sv ***
// Package: constants and carriers for the status word and block map
package csf_pkg;
  localparam int unsigned AW = 24;
  // Status word field positions
  localparam int unsigned STOP_EN_BIT = 15;
  localparam int unsigned MV_BIT      = 14;
  localparam int unsigned HC_BIT      = 13;
  localparam int unsigned EV_BIT      = 12;
  localparam int unsigned N_BIT       = 11;
  localparam int unsigned Z_BIT       = 10;
  localparam int unsigned V_BIT       = 9;
  localparam int unsigned C_BIT       = 8;
  localparam int unsigned IPM_LSB     = 5;
  localparam int unsigned SAT_BIT     = 4;
  localparam int unsigned PK_LSB      = 0;
  localparam logic [15:0] CCS_RESET   = 16'h00e0;
  localparam logic        MAP_RESET   = 1'b1;
  // Peripheral block placement
  localparam logic [11:0] BLK_TAG_LO  = 12'h7ff;
  localparam logic [11:0] BLK_TAG_HI  = 12'hfff;
  // Module groups: offset within block and size in bytes
  localparam logic [11:0] SYS_BASE = 12'ha00;
  localparam logic [11:0] SYS_SIZE = 12'h080;
  localparam logic [11:0] ADC_BASE = 12'h700;
  localparam logic [11:0] ADC_SIZE = 12'h040;
  localparam logic [11:0] SER_BASE = 12'hc00;
  localparam logic [11:0] SER_SIZE = 12'h200;
  localparam logic [11:0] TMR_BASE = 12'h900;
  localparam logic [11:0] TMR_SIZE = 12'h040;
  localparam logic [35:0] ACC_MAX_POS = 36'h7ffffffff;
  localparam logic [35:0] ACC_MAX_NEG = 36'h800000000;

  typedef struct packed {
    logic       stop_en;
    logic       mv;
    logic       hc;
    logic       ev;
    logic       n;
    logic       z;
    logic       v;
    logic       c;
    logic [2:0] ipm;
    logic       sat;
    logic [3:0] pk;
  } csf_ccs_s;

  typedef struct packed {
    logic sys;
    logic adc;
    logic ser;
    logic tmr;
  } csf_sel_s;

  // Flag update bundle from the arithmetic unit
  typedef struct packed {
    logic       valid;
    logic       nz_valid;
    logic [15:0] result;
    logic       is_byte;
    logic       carry;
    logic       ovf;
    logic       cv_valid;
    logic       half_valid;
    logic       half;
  } csf_alu_s;
endpackage : csf_pkg

// *** logic/csf_status_map.sv ***
// Status word, block placement and module decode for the core
// Operation
// - Peripheral block sits at FFF000 when map bit set; no block hit when clear
// - After map bit cleared, internal modules unreachable until reset
// - Map bit resets to one and accepts a single write only
// - Upper address bits 23:20 copy bit 19 unless externally driven
// - Decode system, converter, serial and timer groups at fixed bases
// - Status word layout: stop, flags, priority mask, saturate, pc ext
// - Stop enable clear halts clocks on stop instruction, else no-op
// - Accumulator overflow flag set on overflow into bit 35
// - Half carry set on carry out of bit 3 in decimal add
// - Extension overflow flag set on overflow into bit 31
// - Negative set when operand or result msb is one
// - Zero set when operand or result is all zero
// - Overflow set on two's complement overflow
// - Carry set on carry or borrow, also used by shifts
// - Priority mask 0 to 7 blocks low priority interrupts
// - Saturated accumulator reads when saturate mode and overflow flag
// - Program counter extension joins pc for 20-bit address
// - Accumulator split into upper 35:16 and lower 15:0 parts
`timescale 1ns/1ps
`default_nettype none
module csf_status_map (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ccs_wr_in,
  input  wire logic [15:0]       ccs_wdata_in,
  input  wire csf_pkg::csf_alu_s alu_in,
  input  wire logic              mac_valid_in,
  input  wire logic [35:0]       mac_result_in,
  input  wire logic              mac_ovf35_in,
  input  wire logic              mac_ovf31_in,
  input  wire logic              xfer_rd_in,
  input  wire logic              stop_instr_in,
  input  wire logic              map_wr_in,
  input  wire logic              map_wdata_in,
  input  wire logic [15:0]       pc_in,
  input  wire logic [19:0]       core_addr_in,
  input  wire logic [3:0]        ext_addr_in,
  input  wire logic              ext_addr_drv_in,
  input  wire logic [2:0]        irq_level_in,
  output logic [15:0]            ccs_out,
  output logic [19:0]            fetch_addr_out,
  output logic [23:0]            bus_addr_out,
  output logic                   block_map_select_out,
  output logic                   blk_hit_out,
  output csf_pkg::csf_sel_s      sel_out,
  output logic [19:0]            acc_hi_out,
  output logic [15:0]            acc_lo_out,
  output logic                   clk_halt_out,
  output logic                   irq_take_out
);
  // ----------------------------------------------------------------
  // Synchronised external address drive
  // ----------------------------------------------------------------
  logic [4:0] ext_s1_r;
  logic [4:0] ext_s2_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_s1_r <= 5'h00;
      ext_s2_r <= 5'h00;
    end else begin
      ext_s1_r <= {ext_addr_drv_in, ext_addr_in};
      ext_s2_r <= ext_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  csf_pkg::csf_ccs_s ccs_r;
  csf_pkg::csf_ccs_s ccs_nxt;
  logic [35:0]       acc_r;
  logic              acc_sign_r;
  logic              map_r;
  logic              map_used_r;

  function automatic logic msb_of(input logic [15:0] v, input logic b);
    msb_of = b ? v[7] : v[15];
  endfunction : msb_of

  function automatic logic zero_of(input logic [15:0] v, input logic b);
    zero_of = b ? (v[7:0] == 8'h00) : (v == 16'h0000);
  endfunction : zero_of

  wire logic alu_n = msb_of(alu_in.result, alu_in.is_byte);
  wire logic alu_z = zero_of(alu_in.result, alu_in.is_byte);

  always_comb begin
    ccs_nxt = ccs_r;
    if (ccs_wr_in) begin
      ccs_nxt = csf_pkg::csf_ccs_s'(ccs_wdata_in);
    end
    if (alu_in.valid && alu_in.nz_valid) begin
      ccs_nxt.n = alu_n;
      ccs_nxt.z = alu_z;
    end
    if (alu_in.valid && alu_in.cv_valid) begin
      ccs_nxt.c = alu_in.carry;
      ccs_nxt.v = alu_in.ovf;
    end
    if (alu_in.valid && alu_in.half_valid) begin
      ccs_nxt.hc = alu_in.half;
    end
    // Hardware set wins over a software clear in the same cycle
    if (mac_valid_in && mac_ovf35_in) begin
      ccs_nxt.mv = 1'b1;
    end
    if (mac_valid_in && mac_ovf31_in) begin
      ccs_nxt.ev = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ccs_r <= csf_pkg::csf_ccs_s'(csf_pkg::CCS_RESET);
    end else begin
      ccs_r <= ccs_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and saturated transfer
  // ----------------------------------------------------------------
  // Sign before overflow is captured from the last non-overflowing value
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_r      <= 36'h000000000;
      acc_sign_r <= 1'b0;
    end else if (mac_valid_in) begin
      acc_r <= mac_result_in;
      if (!ccs_r.mv && !ccs_r.ev) begin
        acc_sign_r <= acc_r[35];
      end
    end
  end

  wire logic        sat_now = ccs_r.sat && (ccs_r.mv || ccs_r.ev);
  wire logic [35:0] sat_val = acc_sign_r ? csf_pkg::ACC_MAX_NEG
                                         : csf_pkg::ACC_MAX_POS;
  wire logic [35:0] acc_view = (xfer_rd_in && sat_now) ? sat_val
                                                       : acc_r;

  // ----------------------------------------------------------------
  // Block map bit, single write
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      map_r      <= csf_pkg::MAP_RESET;
      map_used_r <= 1'b0;
    end else if (map_wr_in && !map_used_r) begin
      map_r      <= map_wdata_in;
      map_used_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Address formation and decode
  // ----------------------------------------------------------------
  wire logic [3:0]  upper = ext_s2_r[4] ? ext_s2_r[3:0]
                                        : {4{core_addr_in[19]}};
  wire logic [23:0] full_addr = {upper, core_addr_in};
  wire logic [11:0] blk_tag = map_r ? csf_pkg::BLK_TAG_HI
                                    : csf_pkg::BLK_TAG_LO;
  // Core only reaches the high block; clearing the bit orphans the modules
  wire logic        blk_hit = map_r && (full_addr[23:12] == blk_tag);
  wire logic [11:0] off = full_addr[11:0];

  function automatic logic in_grp(input logic [11:0] a,
                                  input logic [11:0] base,
                                  input logic [11:0] size);
    in_grp = (a >= base) && (a < base + size);
  endfunction : in_grp

  csf_pkg::csf_sel_s sel;
  assign sel.sys = blk_hit && in_grp(off, csf_pkg::SYS_BASE,
                                     csf_pkg::SYS_SIZE);
  assign sel.adc = blk_hit && in_grp(off, csf_pkg::ADC_BASE,
                                     csf_pkg::ADC_SIZE);
  assign sel.ser = blk_hit && in_grp(off, csf_pkg::SER_BASE,
                                     csf_pkg::SER_SIZE);
  assign sel.tmr = blk_hit && in_grp(off, csf_pkg::TMR_BASE,
                                     csf_pkg::TMR_SIZE);

  // Level 7 bypasses the mask so it can never be locked out
  wire logic irq_ok = (irq_level_in == 3'h7) ||
                      (irq_level_in > ccs_r.ipm);
  wire logic halt = stop_instr_in && !ccs_r.stop_en;

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ccs_out              <= 16'h0000;
      fetch_addr_out       <= 20'h00000;
      bus_addr_out         <= 24'h000000;
      block_map_select_out <= 1'b1;
      blk_hit_out          <= 1'b0;
      sel_out              <= '0;
      acc_hi_out           <= 20'h00000;
      acc_lo_out           <= 16'h0000;
      clk_halt_out         <= 1'b0;
      irq_take_out         <= 1'b0;
    end else begin
      ccs_out              <= ccs_r;
      fetch_addr_out       <= {ccs_r.pk, pc_in};
      bus_addr_out         <= full_addr;
      block_map_select_out <= map_r;
      blk_hit_out          <= blk_hit;
      sel_out              <= sel;
      acc_hi_out           <= acc_view[35:16];
      acc_lo_out           <= acc_view[15:0];
      clk_halt_out         <= halt;
      irq_take_out         <= irq_ok && (irq_level_in != 3'h0);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_map_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    map_used_r |=> $stable(map_r)) else $error("map bit rewritten");
  a_map_hide: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !map_r |-> !blk_hit) else $error("modules reachable");
  a_blk_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (map_r && full_addr[23:12] == 12'hfff) |=> blk_hit_out)
    else $error("high block missed");
  a_upper_copy: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ext_s2_r[4] |=> bus_addr_out[23:20] == {4{bus_addr_out[19]}})
    else $error("upper lines wrong");
  a_sys_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (blk_hit && off[11:7] == 5'h14) |=> sel_out.sys)
    else $error("system group miss");
  a_stop_halt: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (stop_instr_in && !ccs_r.stop_en) |=> clk_halt_out)
    else $error("stop not halted");
  a_mv_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mac_valid_in && mac_ovf35_in) |=> ccs_r.mv ##1 ccs_out[14])
    else $error("mv not set");
  a_ev_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mac_valid_in && mac_ovf31_in) |=> ccs_r.ev)
    else $error("ev not set");
  a_zero_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (alu_in.valid && alu_in.nz_valid && !alu_in.is_byte
     && alu_in.result == 16'h0000) |=> ccs_r.z && !ccs_r.n)
    else $error("zero flag wrong");
  a_nmi_take: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    irq_level_in == 3'h7 |=> irq_take_out)
    else $error("level 7 dropped");
  a_sat_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (xfer_rd_in && sat_now && !acc_sign_r) |=>
      {acc_hi_out, acc_lo_out} == 36'h7ffffffff)
    else $error("no saturation");
  // Negative sign before overflow must pick the most negative value
  a_sat_neg: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (xfer_rd_in && sat_now && acc_sign_r) |=>
      {acc_hi_out, acc_lo_out} == 36'h800000000)
    else $error("no negative saturation");
  // Plain reads must show the accumulator untouched, halves in place
  a_acc_split: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !xfer_rd_in |=> {acc_hi_out, acc_lo_out} == $past(acc_r))
    else $error("accumulator halves wrong");

  // ----------------------------------------------------------------
  // Flag and status word checks
  // ----------------------------------------------------------------
  // Software write lands whole when no hardware update competes
  a_ccs_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ccs_wr_in && !alu_in.valid && !mac_valid_in) |=>
      ccs_r == $past(ccs_wdata_in))
    else $error("status write lost");
  a_neg_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (alu_in.valid && alu_in.nz_valid && !alu_in.is_byte
     && alu_in.result[15]) |=> ccs_r.n && !ccs_r.z)
    else $error("negative flag wrong");
  // Byte operations judge zero on the low byte only
  a_zero_byte: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (alu_in.valid && alu_in.nz_valid && alu_in.is_byte
     && alu_in.result[7:0] == 8'h00) |=> ccs_r.z)
    else $error("byte zero flag wrong");
  a_half_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (alu_in.valid && alu_in.half_valid) |=> ccs_r.hc == $past(alu_in.half))
    else $error("half carry wrong");
  a_carry_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (alu_in.valid && alu_in.cv_valid) |=> ccs_r.c == $past(alu_in.carry))
    else $error("carry flag wrong");
  a_ovf_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (alu_in.valid && alu_in.cv_valid) |=> ccs_r.v == $past(alu_in.ovf))
    else $error("overflow flag wrong");
  a_fetch_addr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> fetch_addr_out == {$past(ccs_r.pk), $past(pc_in)})
    else $error("fetch address wrong");

  // ----------------------------------------------------------------
  // Interrupt, stop and decode checks
  // ----------------------------------------------------------------
  // A masked level below 7 must never slip through
  a_irq_mask: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (irq_level_in != 3'h7 && irq_level_in <= ccs_r.ipm) |=> !irq_take_out)
    else $error("masked request taken");
  a_stop_nop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (stop_instr_in && ccs_r.stop_en) |=> !clk_halt_out)
    else $error("stop halted when disabled");
  a_low_block: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !map_r |=> !blk_hit_out)
    else $error("low block reachable");
  a_ext_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ext_s2_r[4] |=> bus_addr_out[23:20] == $past(ext_s2_r[3:0]))
    else $error("external upper lines lost");
  a_adc_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (blk_hit && off[11:6] == 6'h1c) |=> sel_out.adc)
    else $error("converter group miss");
  a_ser_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (blk_hit && off[11:9] == 3'h6) |=> sel_out.ser)
    else $error("serial group miss");
  a_tmr_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (blk_hit && off[11:6] == 6'h24) |=> sel_out.tmr)
    else $error("timer group miss");

  c_map_clear: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    map_wr_in && !map_wdata_in && !map_used_r);
  c_sat: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    xfer_rd_in && sat_now);
  c_ser: cover property (@(posedge clk_in) disable iff (!rst_n_in) sel.ser);
  c_halt: cover property (@(posedge clk_in) disable iff (!rst_n_in) halt);
  c_nmi: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    irq_level_in == 3'h7 && ccs_r.ipm == 3'h7);
endmodule : csf_status_map
`default_nettype wire

// *** testbench/csf_status_map_test.sv ***
// Self-checking bench for the status word and peripheral block map
`timescale 1ns/1ps
`default_nettype none
module csf_status_map_test;
  logic              clk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic              ccs_wr_in = 1'b0;
  logic [15:0]       ccs_wdata_in = 16'h0000;
  csf_pkg::csf_alu_s alu_in = '0;
  logic              mac_valid_in = 1'b0;
  logic [35:0]       mac_result_in = 36'h0;
  logic              mac_ovf35_in = 1'b0;
  logic              mac_ovf31_in = 1'b0;
  logic              xfer_rd_in = 1'b0;
  logic              stop_instr_in = 1'b0;
  logic              map_wr_in = 1'b0;
  logic              map_wdata_in = 1'b0;
  logic [15:0]       pc_in = 16'h0000;
  logic [19:0]       core_addr_in = 20'h00000;
  logic [3:0]        ext_addr_in = 4'h0;
  logic              ext_addr_drv_in = 1'b0;
  logic [2:0]        irq_level_in = 3'h0;
  logic [15:0]       ccs_out;
  logic [19:0]       fetch_addr_out;
  logic [23:0]       bus_addr_out;
  logic              block_map_select_out;
  logic              blk_hit_out;
  csf_pkg::csf_sel_s sel_out;
  logic [19:0]       acc_hi_out;
  logic [15:0]       acc_lo_out;
  logic              clk_halt_out;
  logic              irq_take_out;
  int                bad_count = 0;
  int                checks = 0;
  int                cyc = 0;
  logic [15:0]       e;
  logic [19:0]       adr [12] = '{20'hffa00, 20'hffa7f, 20'hffa80,
    20'hff700, 20'hff73f, 20'hff740, 20'hffc00, 20'hffdff, 20'hffe00,
    20'hff900, 20'hff93f, 20'h7fa00};
  logic [3:0]        sel_e [12] = '{4'h8, 4'h8, 4'h0, 4'h4, 4'h4, 4'h0,
    4'h2, 4'h2, 4'h0, 4'h1, 4'h1, 4'h0};

  csf_status_map DUT (.clk_in, .rst_n_in, .ccs_wr_in, .ccs_wdata_in,
    .alu_in, .mac_valid_in, .mac_result_in, .mac_ovf35_in, .mac_ovf31_in,
    .xfer_rd_in, .stop_instr_in, .map_wr_in, .map_wdata_in, .pc_in,
    .core_addr_in, .ext_addr_in, .ext_addr_drv_in, .irq_level_in,
    .ccs_out, .fetch_addr_out, .bus_addr_out, .block_map_select_out,
    .blk_hit_out, .sel_out, .acc_hi_out, .acc_lo_out, .clk_halt_out,
    .irq_take_out);

  // ---------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ---------------------------------------------------------------
  initial forever #5 clk_in = ~clk_in;

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic cmp_val(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic set_ccs(input logic [15:0] v);
    @(posedge clk_in);
    ccs_wr_in    <= 1'b1;
    ccs_wdata_in <= v;
    @(posedge clk_in);
    ccs_wr_in <= 1'b0;
    tick(3);
  endtask : set_ccs

  // Kind is {nz, cv, half}; flags are {carry, ovf, half}
  task automatic alu(input logic [2:0] kind, input logic b,
                     input logic [2:0] f, input logic [15:0] r);
    csf_pkg::csf_alu_s a;
    a = '0;
    a.valid = 1'b1;
    {a.nz_valid, a.cv_valid, a.half_valid} = kind;
    {a.carry, a.ovf, a.half} = f;
    a.is_byte = b;
    a.result = r;
    @(posedge clk_in);
    alu_in <= a;
    @(posedge clk_in);
    alu_in <= '0;
    tick(3);
  endtask : alu

  task automatic mac(input logic [35:0] r, input logic o35, input logic o31);
    @(posedge clk_in);
    {mac_valid_in, mac_ovf35_in, mac_ovf31_in} <= {1'b1, o35, o31};
    mac_result_in <= r;
    @(posedge clk_in);
    {mac_valid_in, mac_ovf35_in, mac_ovf31_in} <= 3'b000;
    tick(3);
  endtask : mac

  task automatic map_w(input logic d);
    @(posedge clk_in);
    map_wr_in    <= 1'b1;
    map_wdata_in <= d;
    @(posedge clk_in);
    map_wr_in <= 1'b0;
    tick(3);
  endtask : map_w

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    tick(2);
    cmp_val(ccs_out, csf_pkg::CCS_RESET);
    cmp_val(block_map_select_out, 1'b1);
    set_ccs(16'h5a5a);
    cmp_val(ccs_out, 16'h5a5a);
    set_ccs(16'h0000);
    e = 16'h0800;
    alu(3'b100, 1'b0, 3'b000, 16'h8000);
    cmp_val(ccs_out, e);
    e = 16'h0400;
    alu(3'b100, 1'b0, 3'b000, 16'h0000);
    cmp_val(ccs_out, e);
    e = 16'h0800;
    alu(3'b100, 1'b1, 3'b000, 16'h0080);
    cmp_val(ccs_out, e);
    e = 16'h0400;
    alu(3'b100, 1'b1, 3'b000, 16'h0100);
    cmp_val(ccs_out, e);
    e = 16'h0500;
    alu(3'b010, 1'b0, 3'b100, 16'h0000);
    cmp_val(ccs_out, e);
    e = 16'h0600;
    alu(3'b010, 1'b0, 3'b010, 16'h0000);
    cmp_val(ccs_out, e);
    e = 16'h2600;
    alu(3'b001, 1'b0, 3'b001, 16'h0000);
    cmp_val(ccs_out, e);
    // Sign is captured before any overflow, so the first value is positive
    set_ccs(16'h0010);
    mac(36'h123456789, 1'b0, 1'b0);
    cmp_val({acc_hi_out, acc_lo_out}, 36'h123456789);
    mac(36'h080000000, 1'b0, 1'b1);
    cmp_val(ccs_out, 16'h1010);
    xfer_rd_in <= 1'b1;
    tick(2);
    cmp_val({acc_hi_out, acc_lo_out}, csf_pkg::ACC_MAX_POS);
    xfer_rd_in <= 1'b0;
    mac(36'h800000000, 1'b1, 1'b0);
    cmp_val(ccs_out, 16'h5010);
    set_ccs(16'h000a);
    pc_in <= 16'h1234;
    tick(2);
    cmp_val(fetch_addr_out, 20'ha1234);
    for (int m = 0; m < 8; m++) begin
      set_ccs({8'h00, 3'(m), 5'h00});
      for (int l = 0; l < 8; l++) begin
        irq_level_in <= 3'(l);
        tick(2);
        cmp_val(irq_take_out, l != 0 && (l == 7 || l > m));
      end
    end
    for (int i = 0; i < 12; i++) begin
      core_addr_in <= adr[i];
      tick(2);
      cmp_val(bus_addr_out, {{4{adr[i][19]}}, adr[i]});
      cmp_val(blk_hit_out, adr[i][19]);
      cmp_val(sel_out, sel_e[i]);
    end
    // External drive crosses a two-stage synchroniser first
    ext_addr_in     <= 4'h7;
    ext_addr_drv_in <= 1'b1;
    core_addr_in    <= 20'hffa00;
    tick(5);
    cmp_val(bus_addr_out, 24'h7ffa00);
    cmp_val(blk_hit_out, 1'b0);
    map_w(1'b0);
    cmp_val(block_map_select_out, 1'b0);
    cmp_val(blk_hit_out, 1'b0);
    ext_addr_drv_in <= 1'b0;
    map_w(1'b1);
    tick(3);
    cmp_val(block_map_select_out, 1'b0);
    cmp_val(blk_hit_out, 1'b0);
    cmp_val(sel_out, 4'h0);
    set_ccs(16'h8000);
    stop_instr_in <= 1'b1;
    tick(2);
    cmp_val(clk_halt_out, 1'b0);
    stop_instr_in <= 1'b0;
    set_ccs(16'h0000);
    stop_instr_in <= 1'b1;
    tick(2);
    cmp_val(clk_halt_out, 1'b1);
    stop_instr_in <= 1'b0;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    tick(3);
    cmp_val(block_map_select_out, 1'b1);
    cmp_val(blk_hit_out, 1'b1);
    cmp_val(clk_halt_out, 1'b0);
    test_done();
  end
endmodule : csf_status_map_test
`default_nettype wire
